// ==== rtl/dsf_pkg.sv ====
package dsf_pkg;

    // word width and channel count
    localparam int DSF_WORD_W = 9;
    localparam int DSF_CHANNELS = 2;

    // default depth and accepted depth range
    localparam int DSF_DEPTH = 256;
    localparam int DSF_DEPTH_MIN = 16;
    localparam int DSF_DEPTH_MAX = 512;

    // almost-empty / almost-full offsets after reset (empty+7, full-7)
    localparam logic [DSF_WORD_W-1:0] DSF_OFFSET_RESET = 9'h007;

    // write-side configuration caught while the channel reset is held
    typedef enum logic {
        DSF_MODE_PROG_FLAGS,
        DSF_MODE_TWO_WRITE
    } dsf_mode_e;

    localparam dsf_mode_e DSF_MODE_RESET = DSF_MODE_TWO_WRITE;

    // which offset the next offset-register access reaches
    typedef enum logic {
        DSF_SEL_EMPTY,
        DSF_SEL_FULL
    } dsf_sel_e;

    // write port of one channel
    typedef struct packed {
        logic [DSF_WORD_W-1:0] word;
        logic wen_n;
        logic dual_mode;
    } dsf_wr_s;

    // read port of one channel
    typedef struct packed {
        logic ren_first_n;
        logic ren_second_n;
        logic drive_gate_n;
    } dsf_rd_s;

    // status flags of one channel, all active low
    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } dsf_flags_s;

endpackage

// ==== rtl/dsf_rise.sv ====
`timescale 1ns/1ps
`default_nettype none

// rising-edge detector for a port clock sampled on the system clock
module dsf_rise (
    // system side
    input wire logic clk_sys,
    input wire logic rst_b,
    // sampled level and its edge
    input wire logic level,
    output logic rise
);

    logic prev;

    // previous sample of the level
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    // one-cycle pulse on a low-to-high change
    assign rise = level & ~prev;

endmodule // dsf_rise

`default_nettype wire

// ==== rtl/dsf_dual.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// - Each channel has its own 9-bit input word and 9-bit output word, independent of the other.
// - The dual-mode pin is caught during channel reset: high selects a second write enable, low selects offset-register load control.
// - In programmable-flag mode the first write enable and load control gate writes, storing a word when the enable is low, load control high and full high.
// - In two-enable mode a word is stored only when the first enable is low, the second high and full high.
// - While full is low, writes are ignored and memory and write pointer stay put.
// - In programmable-flag mode with load control low, a write edge with enable low loads the offset register instead of the memory.
// - With load control low, a read edge with both read enables low presents an offset instead of memory data.
// - A read edge advances the read side only when both read enables are low and the channel is not empty.
// - Empty goes low exactly when no words are held and changes only on that channel's read clock or reset.
// - Full goes low exactly when no more words fit and changes only on that channel's write clock or reset.
// - Almost-empty goes low when the fill level is at or below its offset and is updated on the read clock.
// - Almost-full goes low when free space is at or below its offset and is updated on the write clock.
// - A channel reset returns that channel to empty and must come before first use.
// - Output words drive the bus while the drive gate is low and float while it is high, whatever the reads do.
// - After reset both offsets are seven words.
module dsf_dual
    import dsf_pkg::*;
#(
    parameter int DEPTH = DSF_DEPTH
) (
    // system
    input wire logic clk_sys,
    input wire logic rst_b,
    // channel resets, active low
    input wire logic channel_reset_one_n,
    input wire logic channel_reset_two_n,
    // write clocks, sampled on clk_sys
    input wire logic write_clock_one,
    input wire logic write_clock_two,
    // read clocks, sampled on clk_sys
    input wire logic read_clock_one,
    input wire logic read_clock_two,
    // write ports
    input wire logic [DSF_WORD_W-1:0] input_word_chan_one,
    input wire logic [DSF_WORD_W-1:0] input_word_chan_two,
    input wire logic primary_write_gate_one_n,
    input wire logic primary_write_gate_two_n,
    input wire logic dual_mode_gate_one,
    input wire logic dual_mode_gate_two,
    // read enables, active low
    input wire logic read_gate_first_one_n,
    input wire logic read_gate_second_one_n,
    input wire logic read_gate_first_two_n,
    input wire logic read_gate_second_two_n,
    // output drive gates, active low
    input wire logic output_drive_gate_one_n,
    input wire logic output_drive_gate_two_n,
    // output words and their drive enables
    output logic [DSF_WORD_W-1:0] output_word_chan_one,
    output logic [DSF_WORD_W-1:0] output_word_chan_two,
    output logic output_word_chan_one_oe,
    output logic output_word_chan_two_oe,
    // flags, active low
    output logic empty_flag_one_n,
    output logic empty_flag_two_n,
    output logic full_flag_one_n,
    output logic full_flag_two_n,
    output logic almost_empty_flag_one_n,
    output logic almost_empty_flag_two_n,
    output logic almost_full_flag_one_n,
    output logic almost_full_flag_two_n
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    // depth must be a power of two whose offsets fit one word
    if ((DEPTH < DSF_DEPTH_MIN) || (DEPTH > DSF_DEPTH_MAX) || ((1 << AW) != DEPTH)) begin : g_bad
        $error("dsf_dual: DEPTH must be a power of two from 16 to 512");
    end

    // true when a level is at or below an offset
    function automatic logic at_or_below(input logic [CW-1:0] level,
                                         input logic [DSF_WORD_W-1:0] offset);
        logic [15:0] l;
        logic [15:0] o;
        l = 16'(level);
        o = 16'(offset);
        return l <= o;
    endfunction

    dsf_wr_s wr_port [DSF_CHANNELS];
    dsf_rd_s rd_port [DSF_CHANNELS];
    dsf_flags_s flags [DSF_CHANNELS];
    logic [DSF_WORD_W-1:0] q_word [DSF_CHANNELS];
    logic chan_rst_n [DSF_CHANNELS];
    logic wr_clk [DSF_CHANNELS];
    logic rd_clk [DSF_CHANNELS];

    // gather the per-channel pins
    assign wr_port[0] = '{input_word_chan_one, primary_write_gate_one_n, dual_mode_gate_one};
    assign wr_port[1] = '{input_word_chan_two, primary_write_gate_two_n, dual_mode_gate_two};
    assign rd_port[0] = '{read_gate_first_one_n, read_gate_second_one_n, output_drive_gate_one_n};
    assign rd_port[1] = '{read_gate_first_two_n, read_gate_second_two_n, output_drive_gate_two_n};
    assign chan_rst_n[0] = channel_reset_one_n;
    assign chan_rst_n[1] = channel_reset_two_n;
    assign wr_clk[0] = write_clock_one;
    assign wr_clk[1] = write_clock_two;
    assign rd_clk[0] = read_clock_one;
    assign rd_clk[1] = read_clock_two;

    // scatter the per-channel results
    assign output_word_chan_one = q_word[0];
    assign output_word_chan_two = q_word[1];
    assign output_word_chan_one_oe = ~rd_port[0].drive_gate_n;
    assign output_word_chan_two_oe = ~rd_port[1].drive_gate_n;
    assign empty_flag_one_n = flags[0].empty_n;
    assign empty_flag_two_n = flags[1].empty_n;
    assign full_flag_one_n = flags[0].full_n;
    assign full_flag_two_n = flags[1].full_n;
    assign almost_empty_flag_one_n = flags[0].almost_empty_n;
    assign almost_empty_flag_two_n = flags[1].almost_empty_n;
    assign almost_full_flag_one_n = flags[0].almost_full_n;
    assign almost_full_flag_two_n = flags[1].almost_full_n;

    for (genvar ch = 0; ch < DSF_CHANNELS; ch++) begin : g_ch
        logic wr_edge;
        logic rd_edge;
        logic [DSF_WORD_W-1:0] mem [DEPTH];
        logic [CW-1:0] wptr;
        logic [CW-1:0] rptr;
        logic [CW-1:0] next_wptr;
        logic [CW-1:0] next_rptr;
        logic [CW-1:0] next_count;
        logic [CW-1:0] next_free;
        dsf_mode_e mode;
        dsf_sel_e wr_sel;
        dsf_sel_e rd_sel;
        logic [DSF_WORD_W-1:0] ae_off;
        logic [DSF_WORD_W-1:0] af_off;
        logic load_ctl;
        logic store;
        logic load;
        logic rd_en;
        logic rd_off;
        logic pop;
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;

        // port clock edges seen on the system clock
        dsf_rise u_wr_rise (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .level(wr_clk[ch]),
            .rise(wr_edge)
        );

        dsf_rise u_rd_rise (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .level(rd_clk[ch]),
            .rise(rd_edge)
        );

        // access decode for this cycle
        assign load_ctl = (mode == DSF_MODE_PROG_FLAGS) && !wr_port[ch].dual_mode;
        assign store = wr_edge && !wr_port[ch].wen_n && wr_port[ch].dual_mode
                       && flags[ch].full_n;
        assign load = wr_edge && !wr_port[ch].wen_n && load_ctl;
        assign rd_en = rd_edge && !rd_port[ch].ren_first_n && !rd_port[ch].ren_second_n;
        assign rd_off = rd_en && load_ctl;
        assign pop = rd_en && !load_ctl && flags[ch].empty_n;

        // pointers and levels after this cycle
        assign next_wptr = wptr + CW'(store);
        assign next_rptr = rptr + CW'(pop);
        assign next_count = next_wptr - next_rptr;
        assign next_free = FULL_COUNT - next_count;

        // configuration caught while the channel reset is held
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                mode <= DSF_MODE_RESET;
            end else if (!chan_rst_n[ch]) begin
                mode <= wr_port[ch].dual_mode ? DSF_MODE_TWO_WRITE : DSF_MODE_PROG_FLAGS;
            end
        end

        // storage array, no reset
        always_ff @(posedge clk_sys) begin
            if (store) begin
                mem[wptr[AW-1:0]] <= wr_port[ch].word;
            end
        end

        // write and read pointers
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                wptr <= '0;
                rptr <= '0;
            end else if (!chan_rst_n[ch]) begin
                wptr <= '0;
                rptr <= '0;
            end else begin
                wptr <= next_wptr;
                rptr <= next_rptr;
            end
        end

        // offset register loads, alternating empty then full
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                ae_off <= DSF_OFFSET_RESET;
                af_off <= DSF_OFFSET_RESET;
                wr_sel <= DSF_SEL_EMPTY;
            end else if (!chan_rst_n[ch]) begin
                ae_off <= DSF_OFFSET_RESET;
                af_off <= DSF_OFFSET_RESET;
                wr_sel <= DSF_SEL_EMPTY;
            end else if (load) begin
                case (wr_sel)
                    DSF_SEL_EMPTY: begin
                        ae_off <= wr_port[ch].word;
                        wr_sel <= DSF_SEL_FULL;
                    end
                    DSF_SEL_FULL: begin
                        af_off <= wr_port[ch].word;
                        wr_sel <= DSF_SEL_EMPTY;
                    end
                    default: wr_sel <= DSF_SEL_EMPTY;
                endcase
            end
        end

        // output word: memory data or an offset read-back
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                q_word[ch] <= '0;
                rd_sel <= DSF_SEL_EMPTY;
            end else if (!chan_rst_n[ch]) begin
                q_word[ch] <= '0;
                rd_sel <= DSF_SEL_EMPTY;
            end else if (rd_off) begin
                case (rd_sel)
                    DSF_SEL_EMPTY: begin
                        q_word[ch] <= ae_off;
                        rd_sel <= DSF_SEL_FULL;
                    end
                    DSF_SEL_FULL: begin
                        q_word[ch] <= af_off;
                        rd_sel <= DSF_SEL_EMPTY;
                    end
                    default: rd_sel <= DSF_SEL_EMPTY;
                endcase
            end else if (pop) begin
                q_word[ch] <= mem[rptr[AW-1:0]];
            end
        end

        // gather the flags so each side keeps a single driver of its own
        assign flags[ch] = '{empty_n, full_n, almost_empty_n, almost_full_n};

        // read-side flags, moved only by read clock edges and resets
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                empty_n <= 1'b0;
                almost_empty_n <= 1'b0;
            end else if (!chan_rst_n[ch]) begin
                empty_n <= 1'b0;
                almost_empty_n <= 1'b0;
            end else if (rd_edge) begin
                empty_n <= (next_count != '0);
                almost_empty_n <= !at_or_below(next_count, ae_off);
            end
        end

        // write-side flags, moved only by write clock edges and resets
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                full_n <= 1'b1;
                almost_full_n <= 1'b1;
            end else if (!chan_rst_n[ch]) begin
                full_n <= 1'b1;
                almost_full_n <= 1'b1;
            end else if (wr_edge) begin
                full_n <= (next_count != FULL_COUNT);
                almost_full_n <= !at_or_below(next_free, af_off);
            end
        end
    end

endmodule // dsf_dual

`default_nettype wire

// ==== dv/dsf_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

// port-level watch on one dual channel block
module dsf_chk
    import dsf_pkg::*;
(
    // clock and resets
    input wire logic clk_sys, rst_b, channel_reset_one_n, channel_reset_two_n,
    // port clocks and gates
    input wire logic write_clock_one, write_clock_two, read_clock_one, read_clock_two,
    input wire logic primary_write_gate_one_n, primary_write_gate_two_n,
    input wire logic dual_mode_gate_one, dual_mode_gate_two,
    input wire logic read_gate_first_one_n, read_gate_second_one_n,
    input wire logic read_gate_first_two_n, read_gate_second_two_n,
    input wire logic output_drive_gate_one_n, output_drive_gate_two_n,
    // data words
    input wire logic [DSF_WORD_W-1:0] input_word_chan_one, input_word_chan_two,
    input wire logic [DSF_WORD_W-1:0] output_word_chan_one, output_word_chan_two,
    // enables and flags
    input wire logic output_word_chan_one_oe, output_word_chan_two_oe,
    input wire logic empty_flag_one_n, empty_flag_two_n, full_flag_one_n, full_flag_two_n,
    input wire logic almost_empty_flag_one_n, almost_empty_flag_two_n,
    input wire logic almost_full_flag_one_n, almost_full_flag_two_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // drive enables mirror the gates
    a_oe_one_gate: assert property (output_word_chan_one_oe == !output_drive_gate_one_n)
        else $error("oe one off its gate");
    a_oe_two_gate: assert property (output_word_chan_two_oe == !output_drive_gate_two_n)
        else $error("oe two off its gate");
    // flags move only on their own port clock rise
    a_full_on_wclk: assert property (
        $changed(full_flag_one_n) && $past(channel_reset_one_n)
        |-> $past(write_clock_one) && !$past(write_clock_one, 2)) else $error("full moved");
    a_empty_on_rclk: assert property (
        $changed(empty_flag_one_n) && $past(channel_reset_one_n)
        |-> $past(read_clock_one) && !$past(read_clock_one, 2)) else $error("empty moved");
    a_aempty_on_rclk: assert property (
        $changed(almost_empty_flag_two_n) && $past(channel_reset_two_n)
        |-> $past(read_clock_two) && !$past(read_clock_two, 2)) else $error("ae moved");
    a_afull_on_wclk: assert property (
        $changed(almost_full_flag_two_n) && $past(channel_reset_two_n)
        |-> $past(write_clock_two) && !$past(write_clock_two, 2)) else $error("af moved");
    // output word changes only on an enabled read rise
    a_out_one_read: assert property (
        $changed(output_word_chan_one) && $past(channel_reset_one_n) |-> $past(read_clock_one)
        && !$past(read_clock_one, 2) && !$past(read_gate_first_one_n)
        && !$past(read_gate_second_one_n)) else $error("word one moved");
    a_out_two_read: assert property (
        $changed(output_word_chan_two) && $past(channel_reset_two_n) |-> $past(read_clock_two)
        && !$past(read_clock_two, 2) && !$past(read_gate_first_two_n)
        && !$past(read_gate_second_two_n)) else $error("word two moved");
    // empty implies almost empty, full implies almost full
    a_empty_implies_ae: assert property (!empty_flag_two_n |-> !almost_empty_flag_two_n)
        else $error("empty without ae");
    a_full_implies_af: assert property (!full_flag_one_n |-> !almost_full_flag_one_n)
        else $error("full without af");
endmodule // dsf_chk

bind dsf_dual dsf_chk u_chk (.*);

`default_nettype wire

// ==== dv/dsf_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// writer and reader logic on both channels; index 0 is channel one
module dsf_host
    import dsf_pkg::*;
(
    // system clock
    input wire logic clk_sys,
    // port lines
    output logic [1:0] ch_rst_n, wclk, rclk, wen_n, dual, ren1_n, ren2_n, oe_n,
    output logic [1:0][DSF_WORD_W-1:0] word
);
    // idle levels; port clocks stand low outside accesses
    initial begin
        {ch_rst_n, wen_n, dual, ren1_n, ren2_n} = '1;
        {wclk, rclk, oe_n} = '0;
        word = '0;
    end
    // channel reset over two edges with the mode pin set
    task automatic chan_reset(input int ch, input logic d);
        @(negedge clk_sys);
        ch_rst_n[ch] = 1'b0;
        dual[ch] = d;
        repeat (2) @(negedge clk_sys);
        ch_rst_n[ch] = 1'b1;
    endtask
    // one write clock period; released data shows its inverse
    task automatic wr(input int ch, input logic [DSF_WORD_W-1:0] w, input logic en, d);
        @(negedge clk_sys);
        word[ch] = w;
        wen_n[ch] = en;
        dual[ch] = d;
        @(negedge clk_sys);
        wclk[ch] = 1'b1;
        @(negedge clk_sys);
        wclk[ch] = 1'b0;
        wen_n[ch] = 1'b1;
        word[ch] = ~w;
    endtask
    // one read clock period
    task automatic rd(input int ch, input logic r1, r2, d);
        @(negedge clk_sys);
        ren1_n[ch] = r1;
        ren2_n[ch] = r2;
        dual[ch] = d;
        @(negedge clk_sys);
        rclk[ch] = 1'b1;
        @(negedge clk_sys);
        rclk[ch] = 1'b0;
        {ren1_n[ch], ren2_n[ch]} = 2'h3;
    endtask
endmodule // dsf_host

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench
    import dsf_pkg::*;
;
    localparam int DEP = 16;
    logic clk_sys, rst_b;
    int failures, n_compared, cycles;
    wire logic [1:0] crn, wc, rc, wen, dm, r1, r2, oen, oe;
    wire logic [1:0][DSF_WORD_W-1:0] wd, outw;
    wire logic [1:0][3:0] flg;
    // reference model: queue, offsets, selectors, flags {e,f,ae,af}, last word
    logic [DSF_WORD_W-1:0] q[2][$];
    int ae[2], af[2];
    bit prog[2], lsel[2], rsel[2];
    logic [3:0] mf[2];
    logic [DSF_WORD_W-1:0] mq[2];

    dsf_host host (.clk_sys(clk_sys), .ch_rst_n(crn), .wclk(wc), .rclk(rc), .wen_n(wen),
        .dual(dm), .ren1_n(r1), .ren2_n(r2), .oe_n(oen), .word(wd));
    dsf_dual #(.DEPTH(DEP)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
        .channel_reset_one_n(crn[0]), .channel_reset_two_n(crn[1]),
        .write_clock_one(wc[0]), .write_clock_two(wc[1]),
        .read_clock_one(rc[0]), .read_clock_two(rc[1]),
        .input_word_chan_one(wd[0]), .input_word_chan_two(wd[1]),
        .primary_write_gate_one_n(wen[0]), .primary_write_gate_two_n(wen[1]),
        .dual_mode_gate_one(dm[0]), .dual_mode_gate_two(dm[1]),
        .read_gate_first_one_n(r1[0]), .read_gate_second_one_n(r2[0]),
        .read_gate_first_two_n(r1[1]), .read_gate_second_two_n(r2[1]),
        .output_drive_gate_one_n(oen[0]), .output_drive_gate_two_n(oen[1]),
        .output_word_chan_one(outw[0]), .output_word_chan_two(outw[1]),
        .output_word_chan_one_oe(oe[0]), .output_word_chan_two_oe(oe[1]),
        .empty_flag_one_n(flg[0][3]), .empty_flag_two_n(flg[1][3]),
        .full_flag_one_n(flg[0][2]), .full_flag_two_n(flg[1][2]),
        .almost_empty_flag_one_n(flg[0][1]), .almost_empty_flag_two_n(flg[1][1]),
        .almost_full_flag_one_n(flg[0][0]), .almost_full_flag_two_n(flg[1][0]));

    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input logic [DSF_WORD_W-1:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_flags(input int ch);
        check({5'h00, flg[ch]}, {5'h00, mf[ch]});
    endtask
    // channel reset on model and design
    task automatic do_reset(input int ch, input logic d);
        host.chan_reset(ch, d);
        q[ch].delete();
        ae[ch] = 7;
        af[ch] = 7;
        prog[ch] = !d;
        {lsel[ch], rsel[ch]} = 2'h0;
        mf[ch] = 4'h5;
        mq[ch] = '0;
        check(outw[ch], mq[ch]);
        chk_flags(ch);
    endtask
    task automatic do_wr(input int ch, input logic [DSF_WORD_W-1:0] w, input logic en, d);
        host.wr(ch, w, en, d);
        if (prog[ch] && !d && !en) begin
            if (lsel[ch]) af[ch] = int'(w);
            else ae[ch] = int'(w);
            lsel[ch] = !lsel[ch];
        end else begin
            if (!en && d && mf[ch][2]) q[ch].push_back(w);
            mf[ch][2] = q[ch].size() < DEP;
            mf[ch][0] = DEP - q[ch].size() > af[ch];
            chk_flags(ch);
        end
    endtask
    task automatic do_rd(input int ch, input logic a, b, d);
        host.rd(ch, a, b, d);
        if (!a && !b) begin
            if (prog[ch] && !d) begin
                mq[ch] = DSF_WORD_W'(rsel[ch] ? af[ch] : ae[ch]);
                rsel[ch] = !rsel[ch];
            end else if (mf[ch][3]) mq[ch] = q[ch].pop_front();
        end
        mf[ch][3] = q[ch].size() > 0;
        mf[ch][1] = q[ch].size() > ae[ch];
        check(outw[ch], mq[ch]);
        chk_flags(ch);
    endtask
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        void'($urandom(32'hd283));
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        // channel one: two enables; reset mid-data empties it and clears the word
        do_reset(0, 1'b1);
        for (int i = 0; i < 3; i++) do_wr(0, DSF_WORD_W'($urandom), 1'b0, 1'b1);
        for (int i = 0; i < 2; i++) do_rd(0, 1'b0, 1'b0, 1'b1);
        do_reset(0, 1'b1);
        do_rd(0, 1'b0, 1'b0, 1'b1);
        // refused writes while there is room, then fill past full
        do_wr(0, DSF_WORD_W'($urandom), 1'b0, 1'b0);
        do_wr(0, DSF_WORD_W'($urandom), 1'b1, 1'b1);
        for (int i = 0; i <= DEP; i++) do_wr(0, DSF_WORD_W'($urandom), 1'b0, 1'b1);
        // gated reads, then drain past empty
        do_rd(0, 1'b1, 1'b0, 1'b1);
        do_rd(0, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i <= DEP; i++) do_rd(0, 1'b0, 1'b0, 1'($urandom));
        // channel two: flag offsets loaded and read back
        do_reset(1, 1'b0);
        do_rd(1, 1'b0, 1'b0, 1'b0);
        do_rd(1, 1'b0, 1'b0, 1'b0);
        do_wr(1, 9'h003, 1'b0, 1'b0);
        do_wr(1, 9'h002, 1'b0, 1'b0);
        do_wr(1, DSF_WORD_W'($urandom), 1'b1, 1'b0);
        do_rd(1, 1'b0, 1'b0, 1'b0);
        do_rd(1, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i <= DEP; i++) do_wr(1, DSF_WORD_W'($urandom), 1'b0, 1'b1);
        for (int i = 0; i <= DEP; i++) do_rd(1, 1'b0, 1'b0, 1'b1);
        // output drive gates
        for (int i = 0; i < 4; i++) begin
            host.oe_n = 2'(i);
            @(negedge clk_sys);
            check({7'h00, oe}, {7'h00, ~2'(i)});
        end
        complete_run();
    end
endmodule // testbench

`default_nettype wire
